// file: common/tcc_timer3_defs.vh
`ifndef TCC_TIMER3_DEFS_VH
`define TCC_TIMER3_DEFS_VH

// Register indexes; byte address is four times the index
`define TCC_IDX_PIN_ACTION   8'h90
`define TCC_IDX_MODE         8'h91
`define TCC_IDX_COUNTER      8'h92
`define TCC_IDX_CMP1         8'h94
`define TCC_IDX_CMP2         8'h96
`define TCC_IDX_CMP3         8'h98
`define TCC_IDX_CH4          8'h9A
`define TCC_IDX_MASK         8'h9C
`define TCC_IDX_FLAGS        8'h9D

// Mode control field positions
`define TCC_MODE_EDGE_HI     7
`define TCC_MODE_EDGE_LO     6
`define TCC_MODE_PRE_HI      5
`define TCC_MODE_PRE_LO      4
`define TCC_MODE_SRC_HI      3
`define TCC_MODE_SRC_LO      2
`define TCC_MODE_HALT        1
`define TCC_MODE_CAPSEL      0

// Field encodings shared by edge, prescale, source and pin action
`define TCC_SEL_00           2'h0
`define TCC_SEL_01           2'h1
`define TCC_SEL_10           2'h2
`define TCC_SEL_11           2'h3

// Prescaler terminal counts for divide by 4 and by 16
`define TCC_DIV4_LAST        4'h3
`define TCC_DIV16_LAST       4'hF

// Reset and preset values
`define TCC_RST_BYTE         8'h00
`define TCC_RST_COUNTER      16'h0000
`define TCC_RST_CMP          16'hFFFF
`define TCC_COUNTER_TOP      16'hFFFF
`define TCC_TEST_PRESET      16'hFFF8
`define TCC_RST_FLAGS        5'h00

`endif

// file: logic/tcc_timer3.v
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`include "tcc_timer3_defs.vh"

module tcc_timer3 (
   input  wire        clock,             // E clock, 50 MHz
   input  wire        resetn,            // Async reset, active low
   input  wire        wb_cyc_i,          // Wishbone cycle
   input  wire        wb_stb_i,          // Wishbone strobe
   input  wire        wb_we_i,           // Wishbone write enable
   input  wire [9:0]  wb_adr_i,          // Wishbone byte address
   input  wire [3:0]  wb_sel_i,          // Wishbone byte selects
   input  wire [31:0] wb_dat_i,          // Wishbone write data
   output reg  [31:0] wb_dat_o,          // Wishbone read data
   output reg         wb_ack_o,          // Wishbone acknowledge
   input  wire        special_mode_flag, // Special test mode
   input  wire        cpu_irq_mask,      // CPU global mask, 1 masks
   input  wire        first_timer_tick,  // First timer rate pulse
   input  wire        ext_count_pin,     // Pin 3 external count input
   output reg  [2:0]  compare_pin_out,   // Pins 4..6 level
   output wire [2:0]  compare_pin_oe,    // Pins 4..6 drive enable
   input  wire        ch4_pin_in,        // Pin 7 input
   output wire        ch4_pin_out,       // Pin 7 level
   output wire        ch4_pin_oe,        // Pin 7 drive enable
   output reg         channel_irq,       // Shared channel interrupt
   output reg         overflow_irq       // Counter overflow interrupt
);

   // Index decode helper used by every register select
   function hit;
      input [7:0] idx;
      input [7:0] target;
      begin
         hit = (idx == target);
      end
   endfunction

   // Byte-lane merge for the compare and channel four registers
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] data;
      input [1:0]  sel;
      begin
         merge16 = {sel[1] ? data[15:8] : old[15:8],
                    sel[0] ? data[7:0]  : old[7:0]};
      end
   endfunction

   reg  [7:0]  pin_action_control;
   reg  [7:0]  mode_control;
   reg         prescale_locked;
   reg         source_locked;
   reg  [15:0] free_counter;
   reg  [15:0] cmp_val [0:3];
   reg  [3:0]  cmp_inhibit;
   reg  [4:0]  irq_enable;
   reg  [4:0]  event_flags;
   reg  [7:0]  low_byte_buf;
   reg         low_buf_valid;
   reg  [3:0]  pre_cnt;
   reg         count_moved;
   reg  [2:0]  ext_sync;
   reg  [2:0]  cap_sync;
   reg         ch4_level;
   reg  [31:0] next_rdata;
   reg  [4:0]  next_flags;
   reg         int_tick;
   reg         tick;
   reg         cap_evt;
   wire        access;
   wire        wr;
   wire        rd;
   wire [7:0]  idx;
   wire [1:0]  edge_sel;
   wire [1:0]  prescale_sel;
   wire [1:0]  source_sel;
   wire        counter_halt;
   wire        ch4_capture_select;
   wire        counter_wr;
   wire        ext_rise;
   wire        ext_fall;
   wire        cap_rise;
   wire        cap_fall;
   wire [3:0]  match;
   wire        wrap;
   wire [2:0]  out_level;
   integer     k;

   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = access & wb_we_i;
   assign rd     = access & ~wb_we_i;
   assign idx    = wb_adr_i[9:2];

   assign edge_sel     = mode_control[`TCC_MODE_EDGE_HI:`TCC_MODE_EDGE_LO];
   assign prescale_sel = mode_control[`TCC_MODE_PRE_HI:`TCC_MODE_PRE_LO];
   assign source_sel   = mode_control[`TCC_MODE_SRC_HI:`TCC_MODE_SRC_LO];
   assign counter_halt       = mode_control[`TCC_MODE_HALT];
   assign ch4_capture_select = mode_control[`TCC_MODE_CAPSEL];
   assign counter_wr = wr & hit(idx, `TCC_IDX_COUNTER) & (|wb_sel_i[1:0]);

   // Bus answer: one registered ack per request, unmapped reads give zero
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= access;
         if (rd)
            wb_dat_o <= next_rdata;
      end
   end

   // Read multiplexer; lone low-byte counter read uses the latched byte
   always @* begin
      next_rdata = 32'h00000000;
      if (hit(idx, `TCC_IDX_PIN_ACTION))
         next_rdata[7:0] = pin_action_control;
      else if (hit(idx, `TCC_IDX_MODE))
         next_rdata[7:0] = mode_control;
      else if (hit(idx, `TCC_IDX_COUNTER)) begin
         next_rdata[15:0] = free_counter;
         if (low_buf_valid && !wb_sel_i[1])
            next_rdata[7:0] = low_byte_buf;
      end else if (hit(idx, `TCC_IDX_CMP1))
         next_rdata[15:0] = cmp_val[0];
      else if (hit(idx, `TCC_IDX_CMP2))
         next_rdata[15:0] = cmp_val[1];
      else if (hit(idx, `TCC_IDX_CMP3))
         next_rdata[15:0] = cmp_val[2];
      else if (hit(idx, `TCC_IDX_CH4))
         next_rdata[15:0] = cmp_val[3];
      else if (hit(idx, `TCC_IDX_MASK))
         next_rdata[7:0] = {irq_enable, 3'h0};
      else if (hit(idx, `TCC_IDX_FLAGS))
         next_rdata[7:0] = {event_flags, 3'h0};
   end

   // Coherent counter read: buffer lives for exactly the next access
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         low_byte_buf  <= `TCC_RST_BYTE;
         low_buf_valid <= 1'b0;
      end else if (access) begin
         low_buf_valid <= 1'b0;
         if (rd && hit(idx, `TCC_IDX_COUNTER) && wb_sel_i[1] &&
             !wb_sel_i[0]) begin
            low_byte_buf  <= free_counter[7:0];
            low_buf_valid <= 1'b1;
         end
      end
   end

   // Control registers; prescale and source fields lock on first write
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pin_action_control <= `TCC_RST_BYTE;
         mode_control       <= `TCC_RST_BYTE;
         prescale_locked    <= 1'b0;
         source_locked      <= 1'b0;
         irq_enable         <= 5'h00;
      end else if (wr && wb_sel_i[0]) begin
         if (hit(idx, `TCC_IDX_PIN_ACTION))
            pin_action_control <= wb_dat_i[7:0];
         if (hit(idx, `TCC_IDX_MODE)) begin
            mode_control[`TCC_MODE_EDGE_HI:`TCC_MODE_EDGE_LO] <=
               wb_dat_i[`TCC_MODE_EDGE_HI:`TCC_MODE_EDGE_LO];
            mode_control[`TCC_MODE_HALT]   <= wb_dat_i[`TCC_MODE_HALT];
            mode_control[`TCC_MODE_CAPSEL] <= wb_dat_i[`TCC_MODE_CAPSEL];
            if (!prescale_locked)
               mode_control[`TCC_MODE_PRE_HI:`TCC_MODE_PRE_LO] <=
                  wb_dat_i[`TCC_MODE_PRE_HI:`TCC_MODE_PRE_LO];
            if (!source_locked)
               mode_control[`TCC_MODE_SRC_HI:`TCC_MODE_SRC_LO] <=
                  wb_dat_i[`TCC_MODE_SRC_HI:`TCC_MODE_SRC_LO];
            prescale_locked <= 1'b1;
            source_locked   <= 1'b1;
         end
         if (hit(idx, `TCC_IDX_MASK))
            irq_enable <= wb_dat_i[7:3];
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ext_sync <= 3'h0;
         cap_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_count_pin};
         cap_sync <= {cap_sync[1:0], ch4_pin_in};
      end
   end

   // Edges count when stages two and three differ
   assign ext_rise = ext_sync[1] & ~ext_sync[2];
   assign ext_fall = ~ext_sync[1] & ext_sync[2];
   assign cap_rise = cap_sync[1] & ~cap_sync[2];
   assign cap_fall = ~cap_sync[1] & cap_sync[2];

   // Prescaler; cleared while halted so restart phase is known
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         pre_cnt <= 4'h0;
      else if (counter_halt)
         pre_cnt <= 4'h0;
      else
         pre_cnt <= pre_cnt + 4'h1;
   end

   // Count tick selection: internal rate or external edges
   always @* begin
      case (prescale_sel)
         `TCC_SEL_00: int_tick = first_timer_tick;
         `TCC_SEL_01: int_tick = 1'b1;
         `TCC_SEL_10: int_tick = (pre_cnt[1:0] == `TCC_DIV4_LAST);
         default:     int_tick = (pre_cnt == `TCC_DIV16_LAST);
      endcase
      // External pin must respect the E/2 and E/4 limits
      case (source_sel)
         `TCC_SEL_00: tick = int_tick;
         `TCC_SEL_01: tick = ext_rise;
         `TCC_SEL_10: tick = ext_fall;
         default:     tick = ext_rise | ext_fall;
      endcase
      case (edge_sel)
         `TCC_SEL_01: cap_evt = cap_rise;
         `TCC_SEL_10: cap_evt = cap_fall;
         `TCC_SEL_11: cap_evt = cap_rise | cap_fall;
         default:     cap_evt = 1'b0;
      endcase
      cap_evt = cap_evt & ch4_capture_select;
   end

   assign wrap = tick & ~counter_halt & ~counter_wr &
                 (free_counter == `TCC_COUNTER_TOP);

   // Free counter: halt beats bus write, bus write beats counting
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         free_counter <= `TCC_RST_COUNTER;
         count_moved  <= 1'b0;
      end else begin
         count_moved <= tick & ~counter_halt & ~counter_wr;
         if (counter_halt)
            free_counter <= `TCC_RST_COUNTER;
         else if (counter_wr) begin
            if (!special_mode_flag)
               free_counter <= `TCC_RST_COUNTER;
            else if (wb_sel_i[1])
               free_counter <= `TCC_TEST_PRESET;
         end else if (tick)
            free_counter <= free_counter + 16'h0001;
      end
   end

   // Compare and channel four registers; capture wins over a bus write
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (k = 0; k < 4; k = k + 1)
            cmp_val[k] <= `TCC_RST_CMP;
         cmp_inhibit <= 4'h0;
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            cmp_inhibit[k] <= 1'b0;
            if (wr && hit(idx, `TCC_IDX_CMP1 + {k[6:0], 1'b0})) begin
               cmp_val[k]     <= merge16(cmp_val[k], wb_dat_i[15:0],
                                         wb_sel_i[1:0]);
               cmp_inhibit[k] <= wb_sel_i[1];
            end
         end
         if (cap_evt)
            cmp_val[3] <= free_counter;
      end
   end

   // Match on each counter step, skipping an inhibited channel
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_chan
         wire [1:0] action;
         wire       allowed;
         assign action  = pin_action_control[7 - 2 * g -: 2];
         assign allowed = (g == 3) ? ~ch4_capture_select : 1'b1;
         assign match[g] = count_moved & ~cmp_inhibit[g] & allowed &
                           (free_counter == cmp_val[g]);
         if (g < 3) begin : g_out
            reg level;
            // Pin action on a successful compare
            always @(posedge clock or negedge resetn) begin
               if (!resetn)
                  level <= 1'b0;
               else if (match[g]) begin
                  case (action)
                     `TCC_SEL_01: level <= ~level;
                     `TCC_SEL_10: level <= 1'b0;
                     `TCC_SEL_11: level <= 1'b1;
                     default:     level <= level;
                  endcase
               end
            end
            assign out_level[g] = level;
            assign compare_pin_oe[g] = (action != `TCC_SEL_00);
         end else begin : g_ch4
            // Channel four level, only driven in compare mode
            always @(posedge clock or negedge resetn) begin
               if (!resetn)
                  ch4_level <= 1'b0;
               else if (match[g]) begin
                  case (action)
                     `TCC_SEL_01: ch4_level <= ~ch4_level;
                     `TCC_SEL_10: ch4_level <= 1'b0;
                     `TCC_SEL_11: ch4_level <= 1'b1;
                     default:     ch4_level <= ch4_level;
                  endcase
               end
            end
            assign ch4_pin_oe = allowed & (action != `TCC_SEL_00);
         end
      end
   endgenerate

   assign ch4_pin_out = ch4_level;

   // One driver for the pin bus; each level lives in its own channel
   always @*
      compare_pin_out = out_level;

   // Event flags: set beats a write-one clear in the same cycle
   always @* begin
      next_flags = event_flags;
      if (wr && wb_sel_i[0] && hit(idx, `TCC_IDX_FLAGS))
         next_flags = event_flags & ~wb_dat_i[7:3];
      next_flags = next_flags |
                   {match[0], match[1], match[2],
                    match[3] | cap_evt, wrap};
   end

   // Interrupt requests, registered, gated by the CPU mask
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         event_flags  <= `TCC_RST_FLAGS;
         channel_irq  <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         event_flags  <= next_flags;
         channel_irq  <= ~cpu_irq_mask &
                         (|(event_flags[4:1] & irq_enable[4:1]));
         overflow_irq <= ~cpu_irq_mask &
                         event_flags[0] & irq_enable[0];
      end
   end

endmodule // tcc_timer3

// file: test/tcc_pin_model.sv
`timescale 1ns/100ps
module tcc_pin_model (
   input  logic clock,            // E clock
   input  logic resetn,           // Reset, active low
   input  logic edge_req,         // Toggle pin 7
   output logic first_timer_tick, // First timer rate
   output logic ext_count_pin,    // Pin 3 input
   output logic ch4_pin_in        // Pin 7 input
);
   logic [2:0] div;
   // Pin 3 period of 8 clocks keeps either edge mode legal
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div <= 3'h0;
         first_timer_tick <= 1'b0;
         ext_count_pin <= 1'b0;
         ch4_pin_in <= 1'b0;
      end else begin
         div <= div + 3'h1;
         first_timer_tick <= (div == 3'h7);
         ext_count_pin <= div[2];
         if (edge_req) ch4_pin_in <= !ch4_pin_in;
      end
   end
endmodule // tcc_pin_model

// file: test/tcc_timer3_properties.sv
`timescale 1ns/100ps
module tcc_timer3_props (
   input logic        clock,           // E clock
   input logic        resetn,          // Reset, active low
   input logic        wb_cyc_i,        // Bus cycle
   input logic        wb_stb_i,        // Bus strobe
   input logic        wb_we_i,         // Bus write
   input logic [31:0] wb_dat_o,        // Read data
   input logic        wb_ack_o,        // Acknowledge
   input logic        cpu_irq_mask,    // Global mask
   input logic [2:0]  compare_pin_out, // Pins 4..6
   input logic [2:0]  compare_pin_oe,  // Pins 4..6 enable
   input logic        ch4_pin_out,     // Pin 7
   input logic        ch4_pin_oe,      // Pin 7 enable
   input logic        channel_irq,     // Channel request
   input logic        overflow_irq     // Overflow request
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Bus answers once, one cycle after the request is taken
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without a request");
   // Read data must not drift between reads
   a_dat_hold: assert property (
      !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      |=> $stable(wb_dat_o)) else $error("read data moved");
   // Global mask silences both requests
   a_chirq_mask: assert property (cpu_irq_mask |=> !channel_irq)
      else $error("channel request while masked");
   a_ovfirq_mask: assert property (cpu_irq_mask |=> !overflow_irq)
      else $error("overflow request while masked");
   // A disconnected pin keeps its level; outputs come out of reset idle
   a_pin_park: assert property (!compare_pin_oe[0] |=>
      $stable(compare_pin_out[0])) else $error("disconnected pin changed");
   a_ch4_park: assert property (!ch4_pin_oe |=> $stable(ch4_pin_out))
      else $error("pin 7 changed while idle");
   a_reset_idle: assert property ($rose(resetn) |->
      compare_pin_out == 3'h0 && !ch4_pin_out && !channel_irq && !overflow_irq)
      else $error("outputs not idle after reset");
endmodule // tcc_timer3_props

bind tcc_timer3 tcc_timer3_props u_props (.clock, .resetn, .wb_cyc_i,
   .wb_stb_i,
   .wb_we_i, .wb_dat_o, .wb_ack_o, .cpu_irq_mask, .compare_pin_out,
   .compare_pin_oe, .ch4_pin_out, .ch4_pin_oe, .channel_irq, .overflow_irq);

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        clock, resetn, cyc, stb, we, smf, cim, edge_req;
   logic        tick, ext_pin, ch4_in, ch4_out, ch4_oe, ch_irq, ov_irq, ack;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o, rd;
   logic [2:0]  pins, oe;
   logic [15:0] lf;
   logic [7:0]  h, l, ix;
   integer      bad_count, check_count, k, e;
   logic [7:0]  ri [8] = '{8'h90, 8'h91, 8'h94, 8'h96, 8'h98, 8'h9A, 8'h9C,
                           8'h93};
   logic [15:0] rv [8] = '{16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                           16'hFFFF, 16'h0, 16'h0};
   // Mode bytes tried after a mid-run reset: sources and divides
   logic [7:0]  md [6] = '{8'h00, 8'h20, 8'h30, 8'h04, 8'h08, 8'h0C};

   tcc_timer3 DUT (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .special_mode_flag(smf),
      .cpu_irq_mask(cim), .first_timer_tick(tick), .ext_count_pin(ext_pin),
      .compare_pin_out(pins), .compare_pin_oe(oe), .ch4_pin_in(ch4_in),
      .ch4_pin_out(ch4_out), .ch4_pin_oe(ch4_oe), .channel_irq(ch_irq),
      .overflow_irq(ov_irq));
   tcc_pin_model u_pins (.clock(clock), .resetn(resetn), .edge_req(edge_req),
      .first_timer_tick(tick), .ext_count_pin(ext_pin), .ch4_pin_in(ch4_in));

   always #10 clock = !clock;

   function automatic [15:0] nx(input [15:0] x);
      nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Counts expected in 64 clocks; model tick and pin 3 repeat every 8
   function automatic integer rate(input [7:0] m);
      if (m[3:2] == 2'h3) rate = 16;
      else if (m[3:2] != 2'h0) rate = 8;
      else if (m[5:4] == 2'h0) rate = 8;
      else if (m[5:4] == 2'h1) rate = 64;
      else if (m[5:4] == 2'h2) rate = 16;
      else rate = 4;
   endfunction

   task results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input [31:0] g, input [31:0] x);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask

   // One classic cycle; held until ack, then one idle cycle
   task wb(input w, input [7:0] i, input [3:0] s, input [31:0] d);
      integer n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; sel <= s; dat <= d;
      @(posedge clock);
      while (ack !== 1'b1 && n < 100) begin @(posedge clock); n++; end
      if (n >= 100) begin
         $display("[FAIL] %0t bus answer missing", $time);
         bad_count++;
         results;
      end
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clock);
   endtask

   // Pin 7 flips once, then settles through the synchroniser
   task pin7;
      edge_req <= 1'b1;
      @(posedge clock);
      edge_req <= 1'b0;
      repeat (8) @(posedge clock);
   endtask

   initial begin
      #400000;
      $display("[FAIL] %0t watchdog expired", $time);
      bad_count++;
      results;
   end

   initial begin
      clock = 0; resetn = 0; cyc = 0; stb = 0; we = 0; adr = 0;
      sel = 0; dat = 0; smf = 0; cim = 0; edge_req = 0;
      lf = 16'h0034; bad_count = 0; check_count = 0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      // Reset values, unmapped odd index last
      for (k = 0; k < 8; k++) begin
         wb(0, ri[k], 4'h3, 0); chk(rd[15:0], rv[k]);
      end
      wb(1, 8'h9C, 4'h1, 32'hFF); wb(0, 8'h9C, 4'h1, 0);
      chk(rd[7:0], 8'hF8);
      wb(1, 8'h93, 4'h3, 32'h1234); wb(0, 8'h93, 4'h3, 0); chk(rd, 0);
      // Random values, whole and upper byte alone
      for (k = 0; k < 3; k++) begin
         lf = nx(lf); ix = 8'h94 + 8'(k * 2);
         wb(1, ix, 4'h3, {16'h0, lf}); wb(0, ix, 4'h3, 0);
         chk(rd[15:0], lf);
         wb(1, ix, 4'h2, {16'h0, ~lf}); wb(0, ix, 4'h3, 0);
         chk(rd[15:0], {~lf[15:8], lf[7:0]});
      end
      // First mode write locks divide by 1; later one cannot move it
      wb(1, 8'h91, 4'h1, 32'h12); wb(1, 8'h91, 4'h1, 32'hEE);
      wb(0, 8'h91, 4'h1, 0); chk(rd[7:0], 8'hD2);
      wb(0, 8'h92, 4'h3, 0); chk(rd[15:0], 0);
      // Two passes of pin actions, all channels matching at 5
      for (e = 0; e < 2; e++) begin
         for (k = 0; k < 4; k++) wb(1, 8'h94 + 8'(k * 2), 4'h3, 32'h5);
         wb(1, 8'h90, 4'h1, e ? 32'h78 : 32'h6F);
         wb(1, 8'h91, 4'h1, 32'hD0);
         repeat (30) @(posedge clock);
         chk(pins, e ? 3'b010 : 3'b101);
         chk({ch4_out, ch4_oe, oe}, {1'b1, !e[0], 3'b111});
         wb(1, 8'h91, 4'h1, 32'hD2);
      end
      chk(ch_irq, 1);
      cim <= 1'b1; repeat (2) @(posedge clock); chk(ch_irq, 0);
      cim <= 1'b0;
      wb(1, 8'h9D, 4'h1, 0); wb(0, 8'h9D, 4'h1, 0);
      chk(rd[7:3], 5'h1E);
      wb(1, 8'h9D, 4'h1, 32'hF0); wb(0, 8'h9D, 4'h1, 0);
      chk(rd[7:3], 0);
      chk(ch_irq, 0);
      // Running counter: write clears, split read stays coherent
      wb(1, 8'h91, 4'h1, 32'hD0); repeat (20) @(posedge clock);
      wb(1, 8'h92, 4'h3, 32'hFFFF); wb(0, 8'h92, 4'h3, 0);
      chk(rd[15:0] < 16'h8, 1);
      wb(0, 8'h92, 4'h2, 0); h = rd[15:8];
      wb(0, 8'h92, 4'h1, 0); l = rd[7:0];
      wb(0, 8'h92, 4'h3, 0); chk(rd[15:0] - {h, l}, 6);
      // Special mode preset, then the wrap sets overflow
      smf <= 1'b1;
      wb(1, 8'h92, 4'h2, 0); wb(0, 8'h92, 4'h3, 0);
      chk(rd[15:3], 13'h1FFF);
      smf <= 1'b0;
      repeat (10) @(posedge clock);
      wb(0, 8'h9D, 4'h1, 0); chk(rd[3], 1);
      chk(ov_irq, 1);
      wb(1, 8'h9D, 4'h1, 32'h08); wb(0, 8'h9D, 4'h1, 0);
      chk(rd[3], 0);
      chk(ov_irq, 0);
      // Capture: rise then fall under each edge code
      for (e = 0; e < 4; e++) begin
         wb(1, 8'h91, 4'h1, {24'h0, e[1:0], 6'h11});
         wb(1, 8'h9A, 4'h3, 32'h5); wb(1, 8'h9D, 4'h1, 32'hF8);
         pin7; wb(0, 8'h9D, 4'h1, 0); chk(rd[4], e[0]);
         pin7; wb(0, 8'h9D, 4'h1, 0); chk(rd[4], e != 0);
         wb(0, 8'h9A, 4'h3, 0); chk(rd[15:0] !== 16'h5, e != 0);
         chk(ch4_oe, 0);
      end
      // Counter reaches 3 as the last write lands: upper byte blocks it
      for (e = 0; e < 2; e++) begin
         wb(1, 8'h91, 4'h1, 32'h12);
         h[0] = pins[0];
         wb(1, 8'h94, 4'h3, e ? 32'h00FF : 32'hFF03);
         wb(1, 8'h91, 4'h1, 32'h10);
         wb(1, 8'h94, e ? 4'h1 : 4'h2, 32'h3);
         repeat (4) @(posedge clock);
         chk(pins[0], h[0] ^ e[0]);
      end
      // Mid-run resets unlock the mode, so each source and every divide but divide by 1 is seen
      for (e = 0; e < 6; e++) begin
         resetn <= 1'b0;
         repeat (2) @(posedge clock);
         resetn <= 1'b1;
         @(posedge clock);
         wb(0, 8'h9A, 4'h3, 0); chk(rd[15:0], 16'hFFFF);
         wb(1, 8'h91, 4'h1, {24'h0, md[e]});
         wb(0, 8'h92, 4'h3, 0);
         {h, l} = rd[15:0];
         repeat (61) @(posedge clock);
         wb(0, 8'h92, 4'h3, 0);
         chk(rd[15:0] - {h, l}, rate(md[e]));
      end
      results;
   end
endmodule // testbench
